// >>> rtl/halt_wakeup_pkg.sv
package halt_wakeup_pkg;

  // Restart delay after any wake-up, in system clock periods
  localparam int unsigned RESTART_CYCLES = 1024;
  localparam int unsigned RESTART_WIDTH = 11;
  localparam logic [RESTART_WIDTH-1:0] RESTART_LAST =
    RESTART_WIDTH'(RESTART_CYCLES - 1);
  localparam logic [RESTART_WIDTH-1:0] RESTART_ZERO = 11'h000;

  // Extra cycles before interrupt service after the restart delay
  localparam int unsigned IRQ_EXTRA_CYCLES = 1;

  // Port A and interrupt source widths
  localparam int unsigned PORTA_WIDTH = 8;
  localparam int unsigned IRQ_WIDTH = 8;

  // Instruction clock is the system clock divided by 4, from a divider this wide
  localparam int unsigned SYSDIV_WIDTH = 2;
  localparam logic [SYSDIV_WIDTH-1:0] SYSDIV_ZERO = 2'h0;
  localparam logic [SYSDIV_WIDTH-1:0] SYSDIV_ONE = 2'h1;

  // Watchdog counter: overflow on the tick after it reaches WDT_LIMIT
  localparam int unsigned WDT_WIDTH = 8;
  localparam logic [WDT_WIDTH-1:0] WDT_ZERO = 8'h00;
  localparam logic [WDT_WIDTH-1:0] WDT_ONE = 8'h01;
  localparam logic [WDT_WIDTH-1:0] WDT_LIMIT = 8'hFF;

  // Power-up values of the status flags
  localparam logic POWER_DOWN_RESET = 1'b0;
  localparam logic TIMEOUT_RESET = 1'b0;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALTED,
    ST_RESTART,
    ST_IRQ_EXTRA
  } state_type;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_EXT_RESET,
    CAUSE_PORTA,
    CAUSE_IRQ,
    CAUSE_WDT
  } cause_type;

endpackage

// >>> rtl/restart_if.sv
`timescale 1ns/10ps
`default_nettype none
interface restart_if;
  logic start;
  logic busy;
  logic done;

  modport ctrl (
    output start,
    input busy,
    input done
  );

  modport counter (
    input start,
    output busy,
    output done
  );
endinterface
`default_nettype wire

// >>> rtl/restart_delay.sv
`timescale 1ns/10ps
`default_nettype none
module restart_delay (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Control
  restart_if.counter rif
);

  logic [halt_wakeup_pkg::RESTART_WIDTH-1:0] count_reg;
  logic [halt_wakeup_pkg::RESTART_WIDTH-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  wire logic at_last;

  assign at_last = (count_reg == halt_wakeup_pkg::RESTART_LAST);

  // Restart from zero on each start, done on the last count
  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (rif.start) begin
      count_next = halt_wakeup_pkg::RESTART_ZERO;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (at_last) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg <= halt_wakeup_pkg::RESTART_ZERO;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign rif.busy = busy_reg;
  assign rif.done = done_reg;

endmodule // restart_delay
`default_nettype wire

// >>> rtl/halt_wakeup_controller.sv
// Summary of operation
// - System clock comes from crystal or RC, fixed by a configuration input.
// - In RC mode the secondary pin pulls low at system clock divided by 4.
// - Watchdog oscillator keeps running in power-down unless configured off.
// - Enabled real-time oscillator becomes timer 3 clock, otherwise timer 3 gets none.
// - Real-time oscillator keeps running through halt and power-down.
// - Only the halt instruction enters power-down.
// - Power-down stops system oscillator and holds core at halt; state is kept.
// - Halt clears watchdog; it counts on if oscillator clocked, else stops.
// - Halt sets power-down flag and clears time-out flag.
// - Wake on external reset, enabled port A fall, interrupt or watchdog overflow.
// - External reset wake resets fully; watchdog wake does a watchdog reset.
// - Power-down flag cleared at power-up and by watchdog clear, set by halt.
// - Watchdog time-out in power-down sets time-out, resets only PC and stack.
// - Each port A pin has its own falling-edge wake enable.
// - Port A wake resumes at the instruction after halt.
// - Disabled or stack-blocked interrupt wake resumes after halt, stays pending.
// - Enabled interrupt with stack free wakes into normal vectoring.
// - Interrupt already requested when halt executes cannot wake the device.
// - Every wake waits 1024 system clock periods before running again.
// - Interrupt service entry waits at least one more cycle after the delay.
// - Resuming after halt executes immediately when the delay ends.
// - Watchdog time-out in normal run resets fully and sets time-out.
`timescale 1ns/10ps
`default_nettype none
module halt_wakeup_controller (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Configuration options
  input wire logic osc_mode_rc_i,
  input wire logic wdt_osc_enable_i,
  input wire logic wdt_clk_from_osc_i,
  input wire logic rtc_enable_i,
  input wire logic [halt_wakeup_pkg::PORTA_WIDTH-1:0] porta_wake_en_i,
  // Pins and other oscillators
  input wire logic external_reset_pin_n_i,
  input wire logic [halt_wakeup_pkg::PORTA_WIDTH-1:0] porta_pin_i,
  input wire logic wdt_osc_clk_i,
  input wire logic rtc_osc_clk_i,
  // Core status and instructions
  input wire logic halt_exec_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic [halt_wakeup_pkg::IRQ_WIDTH-1:0] irq_request_i,
  input wire logic [halt_wakeup_pkg::IRQ_WIDTH-1:0] irq_enable_i,
  input wire logic stack_full_i,
  // Clock control
  output logic sysclk_source_rc_o,
  output logic sysclk_run_o,
  output logic sysclk_osc_output_o,
  output logic sysclk_osc_output_oe_n_o,
  output logic wdt_osc_run_o,
  output logic timer3_clk_o,
  // Core control
  output logic core_hold_o,
  output logic core_reset_full_o,
  output logic core_reset_pcsp_o,
  output logic resume_next_o,
  output logic irq_vector_o,
  output logic [halt_wakeup_pkg::IRQ_WIDTH-1:0] irq_pending_o,
  // Status flags
  output logic power_down_flag_o,
  output logic watchdog_timeout_flag_o
);

  localparam int unsigned PW = halt_wakeup_pkg::PORTA_WIDTH;
  localparam int unsigned IW = halt_wakeup_pkg::IRQ_WIDTH;

  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Two-flop synchronisers for pins and other oscillators
  logic [PW+2:0] sync1_reg;
  logic [PW+2:0] sync2_reg;
  logic [PW+2:0] prev_reg;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      prev_reg <= '1;
    end else begin
      sync1_reg <= {rtc_osc_clk_i, wdt_osc_clk_i, external_reset_pin_n_i,
                    porta_pin_i};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire logic [PW-1:0] porta_s;
  wire logic [PW-1:0] porta_prev;
  wire logic ext_reset_s;
  wire logic wdt_osc_s;
  wire logic wdt_osc_rise;
  wire logic rtc_s;

  assign porta_s = sync2_reg[PW-1:0];
  assign porta_prev = prev_reg[PW-1:0];
  assign ext_reset_s = ~sync2_reg[PW];
  assign wdt_osc_s = sync2_reg[PW+1];
  assign wdt_osc_rise = wdt_osc_s & ~prev_reg[PW+1];
  assign rtc_s = sync2_reg[PW+2];

  // State and cause
  halt_wakeup_pkg::state_type state_reg;
  halt_wakeup_pkg::state_type state_next;
  halt_wakeup_pkg::cause_type cause_reg;
  halt_wakeup_pkg::cause_type cause_next;

  restart_if rif ();

  restart_delay u_restart (
    .clock_i(clock_i),
    .resetn_i(rst_n),
    .rif(rif)
  );

  // Instruction clock divider, stops with the system oscillator
  logic [halt_wakeup_pkg::SYSDIV_WIDTH-1:0] div_reg;
  wire logic sys_running;
  wire logic instr_tick;

  assign sys_running = (state_reg != halt_wakeup_pkg::ST_HALTED);
  assign instr_tick = sys_running & (div_reg == halt_wakeup_pkg::SYSDIV_ZERO);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= halt_wakeup_pkg::SYSDIV_ZERO;
    end else if (sys_running) begin
      div_reg <= div_reg + halt_wakeup_pkg::SYSDIV_ONE;
    end
  end

  // Watchdog counter
  logic [halt_wakeup_pkg::WDT_WIDTH-1:0] wdt_reg;
  logic [halt_wakeup_pkg::WDT_WIDTH-1:0] wdt_next;
  wire logic wdt_tick;
  wire logic wdt_overflow;
  wire logic halt_take;

  assign halt_take = (state_reg == halt_wakeup_pkg::ST_RUN) & halt_exec_i;
  assign wdt_tick = wdt_clk_from_osc_i ?
    (wdt_osc_enable_i & wdt_osc_rise) : instr_tick;
  assign wdt_overflow = wdt_tick & (wdt_reg == halt_wakeup_pkg::WDT_LIMIT);

  always_comb begin
    wdt_next = wdt_reg;
    if (halt_take || watchdog_clear_instruction_i || wdt_overflow ||
        ext_reset_s) begin
      wdt_next = halt_wakeup_pkg::WDT_ZERO;
    end else if (wdt_tick) begin
      wdt_next = wdt_reg + halt_wakeup_pkg::WDT_ONE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reg <= halt_wakeup_pkg::WDT_ZERO;
    end else begin
      wdt_reg <= wdt_next;
    end
  end

  // Interrupts already requested at halt are barred from waking
  logic [IW-1:0] irq_block_reg;
  logic [IW-1:0] pending_reg;
  logic [IW-1:0] pending_next;
  wire logic [IW-1:0] irq_wake_vec;
  wire logic [PW-1:0] porta_fall;
  wire logic porta_wake;
  wire logic irq_wake;
  wire logic irq_serviceable;

  assign porta_fall = porta_prev & ~porta_s;
  assign porta_wake = |(porta_fall & porta_wake_en_i);
  assign irq_wake_vec = irq_request_i & ~irq_block_reg;
  assign irq_wake = |irq_wake_vec;
  assign irq_serviceable = |(pending_reg & irq_enable_i) & ~stack_full_i;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_block_reg <= '0;
    end else if (halt_take) begin
      irq_block_reg <= irq_request_i;
    end
  end

  // State machine
  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    rif.start = 1'b0;
    case (state_reg)
      halt_wakeup_pkg::ST_RUN: begin
        if (halt_take) begin
          state_next = halt_wakeup_pkg::ST_HALTED;
          cause_next = halt_wakeup_pkg::CAUSE_NONE;
        end
      end
      halt_wakeup_pkg::ST_HALTED: begin
        if (ext_reset_s) begin
          cause_next = halt_wakeup_pkg::CAUSE_EXT_RESET;
        end else if (wdt_overflow) begin
          cause_next = halt_wakeup_pkg::CAUSE_WDT;
        end else if (irq_wake) begin
          cause_next = halt_wakeup_pkg::CAUSE_IRQ;
        end else if (porta_wake) begin
          cause_next = halt_wakeup_pkg::CAUSE_PORTA;
        end
        if (ext_reset_s || wdt_overflow || irq_wake || porta_wake) begin
          state_next = halt_wakeup_pkg::ST_RESTART;
          rif.start = 1'b1;
        end
      end
      halt_wakeup_pkg::ST_RESTART: begin
        if (rif.done) begin
          if (cause_reg == halt_wakeup_pkg::CAUSE_IRQ && irq_serviceable) begin
            state_next = halt_wakeup_pkg::ST_IRQ_EXTRA;
          end else begin
            state_next = halt_wakeup_pkg::ST_RUN;
          end
        end
      end
      halt_wakeup_pkg::ST_IRQ_EXTRA: begin
        state_next = halt_wakeup_pkg::ST_RUN;
      end
      default: begin
        state_next = halt_wakeup_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= halt_wakeup_pkg::ST_RUN;
      cause_reg <= halt_wakeup_pkg::CAUSE_NONE;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
    end
  end

  // Wake completion decode
  wire logic wake_done;
  wire logic done_ext;
  wire logic done_wdt;
  wire logic done_porta;
  wire logic done_irq;
  wire logic run_wdt_reset;

  assign wake_done = (state_reg == halt_wakeup_pkg::ST_RESTART) & rif.done;
  assign done_ext = wake_done &
    (cause_reg == halt_wakeup_pkg::CAUSE_EXT_RESET);
  assign done_wdt = wake_done & (cause_reg == halt_wakeup_pkg::CAUSE_WDT);
  assign done_porta = wake_done & (cause_reg == halt_wakeup_pkg::CAUSE_PORTA);
  assign done_irq = wake_done & (cause_reg == halt_wakeup_pkg::CAUSE_IRQ);
  assign run_wdt_reset = (state_reg == halt_wakeup_pkg::ST_RUN) &
    wdt_overflow & ~halt_exec_i;

  // Pending interrupts held while requested, until enabled with stack room
  always_comb begin
    pending_next = pending_reg;
    if (state_reg == halt_wakeup_pkg::ST_HALTED && irq_wake &&
        !ext_reset_s && !wdt_overflow) begin
      pending_next = irq_wake_vec;
    end else if (state_reg == halt_wakeup_pkg::ST_RUN) begin
      pending_next = pending_reg & irq_request_i;
      if (!stack_full_i) begin
        pending_next = pending_next & ~irq_enable_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // Status flags, set wins over clear
  logic power_down_reg;
  logic timeout_reg;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      power_down_reg <= halt_wakeup_pkg::POWER_DOWN_RESET;
      timeout_reg <= halt_wakeup_pkg::TIMEOUT_RESET;
    end else begin
      if (halt_take) begin
        power_down_reg <= 1'b1;
      end else if (watchdog_clear_instruction_i) begin
        power_down_reg <= 1'b0;
      end
      if (done_wdt || run_wdt_reset) begin
        timeout_reg <= 1'b1;
      end else if (halt_take) begin
        timeout_reg <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sysclk_source_rc_o <= 1'b0;
      sysclk_run_o <= 1'b1;
      sysclk_osc_output_o <= 1'b0;
      sysclk_osc_output_oe_n_o <= 1'b1;
      wdt_osc_run_o <= 1'b0;
      timer3_clk_o <= 1'b0;
      core_hold_o <= 1'b0;
      core_reset_full_o <= 1'b0;
      core_reset_pcsp_o <= 1'b0;
      resume_next_o <= 1'b0;
      irq_vector_o <= 1'b0;
      irq_pending_o <= '0;
      power_down_flag_o <= halt_wakeup_pkg::POWER_DOWN_RESET;
      watchdog_timeout_flag_o <= halt_wakeup_pkg::TIMEOUT_RESET;
    end else begin
      sysclk_source_rc_o <= osc_mode_rc_i;
      sysclk_run_o <= (state_next != halt_wakeup_pkg::ST_HALTED);
      sysclk_osc_output_o <= 1'b0;
      sysclk_osc_output_oe_n_o <= ~(osc_mode_rc_i & sys_running &
        ~div_reg[halt_wakeup_pkg::SYSDIV_WIDTH-1]);
      wdt_osc_run_o <= wdt_osc_enable_i;
      timer3_clk_o <= rtc_enable_i & rtc_s;
      core_hold_o <= (state_next != halt_wakeup_pkg::ST_RUN);
      core_reset_full_o <= done_ext | run_wdt_reset |
        ((state_reg == halt_wakeup_pkg::ST_RUN) & ext_reset_s);
      core_reset_pcsp_o <= done_wdt;
      resume_next_o <= done_porta |
        (done_irq & ~irq_serviceable);
      irq_vector_o <= (state_reg == halt_wakeup_pkg::ST_IRQ_EXTRA);
      irq_pending_o <= pending_next;
      power_down_flag_o <= power_down_reg;
      watchdog_timeout_flag_o <= timeout_reg;
    end
  end

endmodule // halt_wakeup_controller
`default_nettype wire

// >>> testbench/halt_wakeup_props.sv
`timescale 1ns/10ps
`default_nettype none
module halt_wakeup_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Watched inputs
  input wire logic osc_mode_rc_i,
  input wire logic wdt_osc_enable_i,
  input wire logic rtc_enable_i,
  input wire logic halt_exec_i,
  input wire logic watchdog_clear_instruction_i,
  // Watched outputs
  input wire logic sysclk_run_o,
  input wire logic sysclk_osc_output_oe_n_o,
  input wire logic wdt_osc_run_o,
  input wire logic timer3_clk_o,
  input wire logic core_hold_o,
  input wire logic core_reset_pcsp_o,
  input wire logic resume_next_o,
  input wire logic irq_vector_o,
  input wire logic power_down_flag_o,
  input wire logic watchdog_timeout_flag_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // Cycles since the system oscillator last started
  logic [11:0] run_cnt;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) run_cnt <= 12'h000;
    else if (!sysclk_run_o) run_cnt <= 12'h000;
    else if (run_cnt != 12'hFFF) run_cnt <= run_cnt + 12'h001;
  end

  a_halt_stops_clock: assert property (
    halt_exec_i && !core_hold_o |=> core_hold_o && !sysclk_run_o)
    else $error("halt did not stop the clock");
  a_halt_sets_flags: assert property (
    halt_exec_i && !core_hold_o |-> ##2
    power_down_flag_o && !watchdog_timeout_flag_o)
    else $error("halt flags wrong");
  a_flag_from_halt: assert property (
    $rose(power_down_flag_o) |-> $past(halt_exec_i, 2))
    else $error("power-down flag set without halt");
  a_clear_drops_flag: assert property (
    watchdog_clear_instruction_i && !halt_exec_i && !core_hold_o
    |-> ##2 !power_down_flag_o)
    else $error("clear did not drop power-down flag");
  a_crystal_no_pull: assert property (
    !osc_mode_rc_i && !$past(osc_mode_rc_i) && !$past(osc_mode_rc_i, 2)
    |-> sysclk_osc_output_oe_n_o)
    else $error("secondary pin pulled in crystal mode");
  a_rc_half_period: assert property (
    $fell(sysclk_osc_output_oe_n_o) && osc_mode_rc_i
    |=> (!sysclk_osc_output_oe_n_o || !sysclk_run_o)
    ##1 sysclk_osc_output_oe_n_o)
    else $error("secondary pin not at quarter rate");
  a_timer3_gated: assert property (
    !rtc_enable_i && !$past(rtc_enable_i) |-> !timer3_clk_o)
    else $error("timer 3 clocked while disabled");
  a_wdt_osc_halted: assert property (
    core_hold_o && wdt_osc_enable_i && $past(wdt_osc_enable_i)
    |-> wdt_osc_run_o)
    else $error("watchdog oscillator stopped in halt");
  a_restart_length: assert property (
    $fell(core_hold_o) |-> run_cnt >= 12'h400 && run_cnt <= 12'h410)
    else $error("restart delay length wrong");
  a_resume_prompt: assert property (
    resume_next_o |-> !core_hold_o && run_cnt >= 12'h400
    && run_cnt <= 12'h404)
    else $error("resume not right after delay");
  a_vector_late: assert property (
    irq_vector_o |-> run_cnt >= 12'h402)
    else $error("vector taken too early");
  a_pcsp_sets_to: assert property (
    core_reset_pcsp_o |-> $past(core_hold_o) ##[0:3] watchdog_timeout_flag_o)
    else $error("watchdog wake without time-out flag");
endmodule // halt_wakeup_props
`default_nettype wire

// >>> testbench/osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module osc_model #(
  parameter int WDT_HALF = 25,
  parameter int RTC_HALF = 150
) (
  // Oscillator enable
  input wire logic wdt_run_i,
  // Oscillator outputs
  output logic wdt_clk_o,
  output logic rtc_clk_o
);
  initial begin
    wdt_clk_o = 1'b0;
    forever #(WDT_HALF) wdt_clk_o = wdt_run_i ? ~wdt_clk_o : 1'b0;
  end
  initial begin
    rtc_clk_o = 1'b0;
    forever #(RTC_HALF) rtc_clk_o = ~rtc_clk_o;
  end
endmodule // osc_model
`default_nettype wire

// >>> testbench/halt_wakeup_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module halt_wakeup_controller_bench;
  logic clock_i, resetn_i, wdt_osc_clk_i, rtc_osc_clk_i;
  logic osc_mode_rc_i = 1'b0, wdt_osc_enable_i = 1'b0, rtc_enable_i = 1'b0;
  logic wdt_clk_from_osc_i = 1'b1, external_reset_pin_n_i = 1'b1;
  logic halt_exec_i = 1'b0, watchdog_clear_instruction_i = 1'b0;
  logic stack_full_i = 1'b0;
  logic [halt_wakeup_pkg::PORTA_WIDTH-1:0] porta_wake_en_i = 8'h01;
  logic [halt_wakeup_pkg::PORTA_WIDTH-1:0] porta_pin_i = 8'hFF;
  logic [halt_wakeup_pkg::IRQ_WIDTH-1:0] irq_request_i = 8'h00;
  logic [halt_wakeup_pkg::IRQ_WIDTH-1:0] irq_enable_i = 8'h00;
  logic sysclk_source_rc_o, sysclk_run_o, sysclk_osc_output_o;
  logic sysclk_osc_output_oe_n_o, wdt_osc_run_o, timer3_clk_o, core_hold_o;
  logic core_reset_full_o, core_reset_pcsp_o, resume_next_o, irq_vector_o;
  logic power_down_flag_o, watchdog_timeout_flag_o;
  logic [halt_wakeup_pkg::IRQ_WIDTH-1:0] irq_pending_o;
  logic [3:0] pulses, halt_view;
  logic [1:0] watch;
  logic [7:0] reset_view;
  int n = 0, num_errors = 0, checks = 0;

  assign pulses = {irq_vector_o, resume_next_o, core_reset_pcsp_o,
    core_reset_full_o};
  assign halt_view = {core_hold_o, sysclk_run_o, power_down_flag_o,
    watchdog_timeout_flag_o};
  assign watch = {timer3_clk_o, sysclk_osc_output_oe_n_o};
  assign reset_view = {sysclk_run_o, sysclk_osc_output_oe_n_o, core_hold_o,
    power_down_flag_o, watchdog_timeout_flag_o, sysclk_source_rc_o,
    timer3_clk_o, sysclk_osc_output_o};

  halt_wakeup_controller u_dut (.clock_i, .resetn_i, .osc_mode_rc_i,
    .wdt_osc_enable_i, .wdt_clk_from_osc_i, .rtc_enable_i, .porta_wake_en_i,
    .external_reset_pin_n_i, .porta_pin_i, .wdt_osc_clk_i, .rtc_osc_clk_i,
    .halt_exec_i, .watchdog_clear_instruction_i, .irq_request_i,
    .irq_enable_i, .stack_full_i, .sysclk_source_rc_o, .sysclk_run_o,
    .sysclk_osc_output_o, .sysclk_osc_output_oe_n_o, .wdt_osc_run_o,
    .timer3_clk_o, .core_hold_o, .core_reset_full_o, .core_reset_pcsp_o,
    .resume_next_o, .irq_vector_o, .irq_pending_o, .power_down_flag_o,
    .watchdog_timeout_flag_o);

  osc_model u_osc (.wdt_run_i(wdt_osc_run_o), .wdt_clk_o(wdt_osc_clk_i),
    .rtc_clk_o(rtc_osc_clk_i));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for one of the result pulses
  task automatic wait_out(input int idx, input int lim);
    n = 0;
    while (pulses[idx] !== 1'b1) begin
      @(negedge clock_i);
      n++;
      if (n > lim) begin
        num_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
      end
    end
  endtask

  task automatic count_edges(input int idx, input int cyc);
    logic prev;
    n = 0;
    prev = watch[idx];
    repeat (cyc) begin
      @(negedge clock_i);
      if (watch[idx] !== prev) n++;
      prev = watch[idx];
    end
  endtask

  task automatic do_halt();
    halt_exec_i = 1'b1;
    @(negedge clock_i);
    halt_exec_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check(8'(halt_view), 8'h0A);
  endtask

  task automatic pulse_clear();
    watchdog_clear_instruction_i = 1'b1;
    @(negedge clock_i);
    watchdog_clear_instruction_i = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask

  initial begin
    resetn_i = 1'b0;
    repeat (3) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (6) @(negedge clock_i);
    check(reset_view, 8'hC0);
    count_edges(1, 48);
    check(8'(n), 8'h00);
    rtc_enable_i = 1'b1;
    count_edges(1, 48);
    check(8'(n >= 6), 8'h01);
    osc_mode_rc_i = 1'b1;
    repeat (4) @(negedge clock_i);
    count_edges(0, 16);
    check(8'(n), 8'h08);
    check(8'({sysclk_source_rc_o, sysclk_osc_output_o}), 8'h02);
    // Pending request at halt, then a disabled pin falls
    irq_request_i = 8'h01;
    do_halt();
    porta_pin_i = 8'hFD;
    count_edges(1, 48);
    check(8'(n >= 6), 8'h01);
    check(8'({core_hold_o, sysclk_osc_output_oe_n_o}), 8'h03);
    porta_pin_i = 8'hFC;
    wait_out(2, 1100);
    check(8'(n >= 1024 && n <= 1036), 8'h01);
    porta_pin_i = 8'hFF;
    irq_request_i = 8'h00;
    pulse_clear();
    check(8'(power_down_flag_o), 8'h00);
    osc_mode_rc_i = 1'b0;
    // Serviceable, disabled and stack-blocked interrupt wakes
    for (int k = 0; k < 3; k++) begin
      do_halt();
      irq_enable_i = (k == 1) ? 8'h00 : 8'h04;
      stack_full_i = (k == 2);
      irq_request_i = 8'h04;
      wait_out((k == 0) ? 3 : 2, 1200);
      check(8'(n >= 1025), 8'h01);
      @(negedge clock_i);
      check(irq_pending_o, (k == 0) ? 8'h00 : 8'h04);
      irq_request_i = 8'h00;
      irq_enable_i = 8'h00;
      stack_full_i = 1'b0;
      repeat (4) @(negedge clock_i);
    end
    do_halt();
    external_reset_pin_n_i = 1'b0;
    repeat (4) @(negedge clock_i);
    external_reset_pin_n_i = 1'b1;
    wait_out(0, 1200);
    check(8'(n >= 1000), 8'h01);
    // Watchdog overflow while running, then while halted
    wdt_osc_enable_i = 1'b1;
    pulse_clear();
    wait_out(0, 1200);
    check(8'(n >= 500), 8'h01);
    repeat (3) @(negedge clock_i);
    check(8'(watchdog_timeout_flag_o), 8'h01);
    do_halt();
    check(8'(wdt_osc_run_o), 8'h01);
    wait_out(1, 2000);
    repeat (3) @(negedge clock_i);
    check(8'({power_down_flag_o, watchdog_timeout_flag_o}), 8'h03);
    wdt_osc_enable_i = 1'b0;
    // Watchdog on the instruction clock counts in run, stops in halt
    wdt_clk_from_osc_i = 1'b0;
    pulse_clear();
    wait_out(0, 1100);
    check(8'(n >= 1000), 8'h01);
    do_halt();
    repeat (2200) @(negedge clock_i);
    check(8'({core_hold_o, sysclk_run_o}), 8'h02);
    stop_test();
  end
endmodule // halt_wakeup_controller_bench

bind halt_wakeup_controller halt_wakeup_props u_props (.clock_i, .resetn_i,
  .osc_mode_rc_i, .wdt_osc_enable_i, .rtc_enable_i, .halt_exec_i,
  .watchdog_clear_instruction_i, .sysclk_run_o, .sysclk_osc_output_oe_n_o,
  .wdt_osc_run_o, .timer3_clk_o, .core_hold_o, .core_reset_pcsp_o,
  .resume_next_o, .irq_vector_o, .power_down_flag_o,
  .watchdog_timeout_flag_o);
`default_nettype wire
